// ===== core/acsc_consts.svh
`ifndef ACSC_CONSTS_SVH
`define ACSC_CONSTS_SVH

// register offsets
`define ACSC_OFS_SYS_CTRL_ONE 8'h2a
`define ACSC_OFS_SYS_CTRL_TWO 8'h2b
`define ACSC_OFS_IRQ_WAKE_CTRL 8'h2c

// reset values
`define ACSC_RST_SYS_CTRL_ONE 8'h00
`define ACSC_RST_SYS_CTRL_TWO 8'h00
`define ACSC_RST_IRQ_WAKE_CTRL 8'h00

// system_control_one fields
`define ACSC_F1_SLEEP_RATE_HI 7
`define ACSC_F1_SLEEP_RATE_LO 6
`define ACSC_F1_WAKE_RATE_HI 5
`define ACSC_F1_WAKE_RATE_LO 3
`define ACSC_F1_LOW_NOISE 2
`define ACSC_F1_FAST_READ 1
`define ACSC_F1_ACTIVE 0

// system_control_two fields
`define ACSC_F2_SELF_TEST 7
`define ACSC_F2_SOFT_RESET 6
`define ACSC_F2_ZERO 5
`define ACSC_F2_SLEEP_OS_HI 4
`define ACSC_F2_SLEEP_OS_LO 3
`define ACSC_F2_AUTO_SLEEP 2
`define ACSC_F2_WAKE_OS_HI 1
`define ACSC_F2_WAKE_OS_LO 0

// interrupt_wake_control fields
`define ACSC_F3_FIFO_GATE 7
`define ACSC_F3_WAKE_TRANSIENT 6
`define ACSC_F3_WAKE_ORIENT 5
`define ACSC_F3_WAKE_PULSE 4
`define ACSC_F3_WAKE_FALL_MOTION 3
`define ACSC_F3_UNUSED 2
`define ACSC_F3_IRQ_POLARITY 1
`define ACSC_F3_IRQ_DRIVE 0

// writable mask of system_control_two: bit 5 stays zero, bit 6 self-clears
`define ACSC_TWO_STORE_MASK 8'h9f
// writable mask of interrupt_wake_control: bit 2 unused
`define ACSC_THREE_STORE_MASK 8'hfb

// fifo mode code meaning the fifo is off
`define ACSC_FIFO_MODE_OFF 2'h0

// low-noise saturation in counts (4 g at 1024 counts per g)
`define ACSC_LOW_NOISE_LIMIT 14'sd4095

// output data register span walked by the auto-increment pointer
`define ACSC_DATA_FIRST 8'h01
`define ACSC_DATA_LAST 8'h06

// software reset boot time
`define ACSC_CLK_PERIOD_NS 10
`define ACSC_BOOT_TIME_NS 1000
`define ACSC_BOOT_CYCLES \
    ((`ACSC_BOOT_TIME_NS + `ACSC_CLK_PERIOD_NS - 1) / `ACSC_CLK_PERIOD_NS)

`endif

// ===== core/acsc_pkg.sv
package acsc_pkg;

    // oversampling scheme codes
    typedef enum logic [1:0] {
        ACSC_OS_NORMAL = 2'h0,
        ACSC_OS_LOW_NOISE_LOW_POWER = 2'h1,
        ACSC_OS_HIGH_RES = 2'h2,
        ACSC_OS_LOW_POWER = 2'h3
    } acsc_os_scheme_t;

    // soft reset sequencer
    typedef enum logic {
        ACSC_RUN,
        ACSC_BOOT
    } acsc_state_t;

endpackage : acsc_pkg

// ===== core/acsc_rate_decode.sv
`timescale 1ns/1ps
// turns a rate code and oversampling scheme into sample period and ratio
module acsc_rate_decode (
    input wire logic [2:0] rate_code,
    input wire acsc_pkg::acsc_os_scheme_t scheme,
    output logic [19:0] period_us,
    output logic [10:0] os_ratio
);
    import acsc_pkg::*;

    // sample period in microseconds per rate code
    always_comb begin
        unique case (rate_code)
            3'h0: period_us = 20'h004e2; // 800 Hz, 1.25 ms
            3'h1: period_us = 20'h009c4; // 400 Hz
            3'h2: period_us = 20'h01388; // 200 Hz
            3'h3: period_us = 20'h02710; // 100 Hz
            3'h4: period_us = 20'h04e20; // 50 Hz
            3'h5: period_us = 20'h13880; // 12.5 Hz
            3'h6: period_us = 20'h27100; // 6.25 Hz
            3'h7: period_us = 20'h9c400; // 1.56 Hz, 640 ms
        endcase
    end

    // averaging ratio per scheme and rate
    always_comb begin
        os_ratio = 11'h002;
        unique case (scheme)
            ACSC_OS_NORMAL: begin
                unique case (rate_code)
                    3'h0: os_ratio = 11'h002;
                    3'h5: os_ratio = 11'h010;
                    3'h6: os_ratio = 11'h020;
                    3'h7: os_ratio = 11'h080;
                    default: os_ratio = 11'h004; // 400 to 50 Hz
                endcase
            end
            ACSC_OS_LOW_NOISE_LOW_POWER: begin
                unique case (rate_code)
                    3'h0: os_ratio = 11'h002;
                    3'h6: os_ratio = 11'h008;
                    3'h7: os_ratio = 11'h020;
                    default: os_ratio = 11'h004;
                endcase
            end
            ACSC_OS_HIGH_RES: begin
                unique case (rate_code)
                    3'h0: os_ratio = 11'h002;
                    3'h1: os_ratio = 11'h004;
                    3'h2: os_ratio = 11'h008;
                    3'h3: os_ratio = 11'h010;
                    3'h4: os_ratio = 11'h020;
                    3'h5: os_ratio = 11'h080;
                    3'h6: os_ratio = 11'h100;
                    3'h7: os_ratio = 11'h400;
                endcase
            end
            ACSC_OS_LOW_POWER: begin
                unique case (rate_code)
                    3'h6: os_ratio = 11'h004;
                    3'h7: os_ratio = 11'h010;
                    default: os_ratio = 11'h002;
                endcase
            end
        endcase
    end

endmodule : acsc_rate_decode

// ===== core/acsc_sys_ctrl.sv
`timescale 1ns/1ps
// Function
// (R1) host enters standby before changing control one
// (R2) control one field layout, all zero reset
// (R3) sleep rate codes 50/12.5/6.25/1.56 Hz
// (R4) auto-sleep runs everything at sleep rate
// (R5) wake rate codes 800 to 1.56 Hz
// (R6) active bit: 0 standby, 1 active
// (R7) low noise saturates signal at 4 g
// (R8) fast read skips low data bytes
// (R9) host changes fast read only fifo off
// (R10) control two field layout, zero reset
// (R11) self test shifts axis outputs
// (R12) soft reset reloads every register default
// (R13) soft reset also resets serial logic
// (R14) soft reset self-clears, reads as zero
// (R15) oversampling scheme code meanings
// (R16) averaging ratio by scheme and rate
// (R17) auto-sleep enable permits sleep transition
// (R18) interrupt wake control field layout
// (R19) fifo gate: flush or hold on transition
// (R20) wake enables let functions wake system
// (R21) irq polarity and drive type select
// (R22) active writes change only active bit
`include "acsc_consts.svh"
module acsc_sys_ctrl (
    input wire logic clk_sys,
    input wire logic resetn,
    // register port from the serial interface
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // auto-increment pointer
    input wire logic [7:0] ptr_cur,
    output logic [7:0] ptr_next,
    // sleep state from the inactivity timer
    input wire logic asleep,
    // fifo side
    input wire logic [1:0] fifo_operating_mode,
    input wire logic fifo_empty,
    output logic fifo_flush,
    output logic fifo_input_block,
    output logic fifo_msb_only,
    // wake sources
    input wire logic transient_event,
    input wire logic orientation_event,
    input wire logic pulse_event,
    input wire logic fall_motion_event,
    output logic wake_request,
    // sample path clamp
    input wire logic signed [13:0] sample_in,
    output logic signed [13:0] sample_out,
    // control outputs
    output logic active_mode,
    output logic sleep_allowed,
    output logic self_test_enable,
    output logic low_noise_select,
    output logic irq_polarity,
    output logic irq_drive_type,
    output logic [2:0] run_rate_code,
    output acsc_pkg::acsc_os_scheme_t run_scheme,
    output logic [19:0] run_period_us,
    output logic [10:0] run_os_ratio,
    output logic serial_reset
);
    import acsc_pkg::*;

    localparam logic [7:0] BOOT_LAST = 8'(`ACSC_BOOT_CYCLES - 1);

    logic [7:0] ctrl_one_q, ctrl_one_d; // system_control_one
    logic [7:0] ctrl_two_q, ctrl_two_d; // system_control_two
    logic [7:0] ctrl_three_q, ctrl_three_d; // interrupt_wake_control
    acsc_state_t state_q, state_d; // soft reset sequencer
    logic [7:0] boot_cnt_q, boot_cnt_d; // boot timer
    logic [7:0] rdata_q, rdata_d; // registered read data
    logic asleep_q, asleep_d; // previous sleep state
    logic block_q, block_d; // fifo input held by gate
    logic flush_q, flush_d; // flush pulse

    // register decode, used by write and read paths
    function automatic logic [1:0] reg_index(input logic [7:0] a);
        unique case (a)
            `ACSC_OFS_SYS_CTRL_ONE: reg_index = 2'h1;
            `ACSC_OFS_SYS_CTRL_TWO: reg_index = 2'h2;
            `ACSC_OFS_IRQ_WAKE_CTRL: reg_index = 2'h3;
            default: reg_index = 2'h0;
        endcase
    endfunction : reg_index

    // fields
    logic [1:0] sleep_sample_rate;
    logic [2:0] wake_data_rate;
    logic fast_read;
    logic auto_sleep_enable;
    acsc_os_scheme_t sleep_oversampling_scheme;
    acsc_os_scheme_t wake_oversampling_scheme;
    logic fifo_gate;
    logic in_sleep;

    assign sleep_sample_rate = ctrl_one_q[`ACSC_F1_SLEEP_RATE_HI:
                                          `ACSC_F1_SLEEP_RATE_LO]; // [R2]
    assign wake_data_rate = ctrl_one_q[`ACSC_F1_WAKE_RATE_HI:
                                       `ACSC_F1_WAKE_RATE_LO]; // [R2]
    assign low_noise_select = ctrl_one_q[`ACSC_F1_LOW_NOISE];
    assign fast_read = ctrl_one_q[`ACSC_F1_FAST_READ];
    assign active_mode = ctrl_one_q[`ACSC_F1_ACTIVE]; // [R6]
    assign self_test_enable = ctrl_two_q[`ACSC_F2_SELF_TEST]; // [R11]
    assign auto_sleep_enable = ctrl_two_q[`ACSC_F2_AUTO_SLEEP];
    assign sleep_oversampling_scheme = acsc_os_scheme_t'(
        ctrl_two_q[`ACSC_F2_SLEEP_OS_HI:`ACSC_F2_SLEEP_OS_LO]); // [R15]
    assign wake_oversampling_scheme = acsc_os_scheme_t'(
        ctrl_two_q[`ACSC_F2_WAKE_OS_HI:`ACSC_F2_WAKE_OS_LO]); // [R15]
    assign fifo_gate = ctrl_three_q[`ACSC_F3_FIFO_GATE];
    assign irq_polarity = ctrl_three_q[`ACSC_F3_IRQ_POLARITY]; // [R21]
    assign irq_drive_type = ctrl_three_q[`ACSC_F3_IRQ_DRIVE]; // [R21]

    // sleep only counts while active and enabled
    assign sleep_allowed = auto_sleep_enable & active_mode; // [R17]
    assign in_sleep = asleep & sleep_allowed;

    // sleep codes sit on top of the wake table: 00 -> 50 Hz code 4
    always_comb begin
        if (in_sleep) begin
            run_rate_code = {1'b1, sleep_sample_rate}; // [R3] [R4]
            run_scheme = sleep_oversampling_scheme; // [R4]
        end else begin
            run_rate_code = wake_data_rate; // [R5]
            run_scheme = wake_oversampling_scheme;
        end
    end

    // period and averaging ratio of the running rate
    acsc_rate_decode u_rate (
        .rate_code(run_rate_code),
        .scheme(run_scheme),
        .period_us(run_period_us), // [R5]
        .os_ratio(run_os_ratio) // [R16]
    );

    // register write path and soft reset sequencing
    always_comb begin
        ctrl_one_d = ctrl_one_q;
        ctrl_two_d = ctrl_two_q;
        ctrl_three_d = ctrl_three_q;
        state_d = state_q;
        boot_cnt_d = boot_cnt_q;
        unique case (state_q)
            ACSC_RUN: begin
                if (reg_wr) begin
                    unique case (reg_index(reg_addr))
                        2'h1: begin
                            if (active_mode) begin
                                // other fields frozen while running
                                ctrl_one_d[`ACSC_F1_ACTIVE] =
                                    reg_wdata[`ACSC_F1_ACTIVE]; // [R22] [R1]
                            end else begin
                                ctrl_one_d = reg_wdata; // [R2]
                                // fast read frozen while fifo runs
                                if (fifo_operating_mode !=
                                    `ACSC_FIFO_MODE_OFF) begin
                                    ctrl_one_d[`ACSC_F1_FAST_READ] =
                                        fast_read; // [R9]
                                end
                            end
                        end
                        2'h2: begin
                            if (reg_wdata[`ACSC_F2_SOFT_RESET]) begin
                                // reload defaults at once, any mode
                                ctrl_one_d = `ACSC_RST_SYS_CTRL_ONE; // [R12]
                                ctrl_two_d = `ACSC_RST_SYS_CTRL_TWO; // [R12]
                                ctrl_three_d =
                                    `ACSC_RST_IRQ_WAKE_CTRL; // [R12]
                                state_d = ACSC_BOOT;
                                boot_cnt_d = 8'h00;
                            end else begin
                                ctrl_two_d = reg_wdata &
                                    `ACSC_TWO_STORE_MASK; // [R10]
                            end
                        end
                        2'h3: ctrl_three_d = reg_wdata &
                            `ACSC_THREE_STORE_MASK; // [R18]
                        default: ;
                    endcase
                end
            end
            ACSC_BOOT: begin
                // writes dropped while booting; back to run at the end
                if (boot_cnt_q == BOOT_LAST) begin
                    state_d = ACSC_RUN; // [R14]
                end else begin
                    boot_cnt_d = boot_cnt_q + 8'h01;
                end
            end
        endcase
    end

    // control registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_one_q <= `ACSC_RST_SYS_CTRL_ONE; // [R2]
            ctrl_two_q <= `ACSC_RST_SYS_CTRL_TWO; // [R10]
            ctrl_three_q <= `ACSC_RST_IRQ_WAKE_CTRL;
            state_q <= ACSC_RUN;
            boot_cnt_q <= 8'h00;
        end else begin
            ctrl_one_q <= ctrl_one_d;
            ctrl_two_q <= ctrl_two_d;
            ctrl_three_q <= ctrl_three_d;
            state_q <= state_d;
            boot_cnt_q <= boot_cnt_d;
        end
    end

    // serial logic held in reset for the boot time
    assign serial_reset = (state_q == ACSC_BOOT); // [R13]

    // read path; soft reset bit is never stored so reads zero
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_index(reg_addr))
                2'h1: rdata_d = ctrl_one_q;
                2'h2: rdata_d = ctrl_two_q; // [R14]
                2'h3: rdata_d = ctrl_three_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_hit = (reg_index(reg_addr) != 2'h0);

    // pointer walk: fast read visits only the high data bytes
    always_comb begin
        ptr_next = ptr_cur + 8'h01;
        if (fast_read && ptr_cur >= `ACSC_DATA_FIRST &&
            ptr_cur < `ACSC_DATA_LAST) begin
            ptr_next = ptr_cur + 8'h02; // [R8]
        end
    end
    assign fifo_msb_only = fast_read; // [R8]

    // wake only from enabled functions while asleep
    assign wake_request = in_sleep &
        ((transient_event & ctrl_three_q[`ACSC_F3_WAKE_TRANSIENT]) |
         (orientation_event & ctrl_three_q[`ACSC_F3_WAKE_ORIENT]) |
         (pulse_event & ctrl_three_q[`ACSC_F3_WAKE_PULSE]) |
         (fall_motion_event &
          ctrl_three_q[`ACSC_F3_WAKE_FALL_MOTION])); // [R20]

    // fifo gating on wake/sleep transitions
    always_comb begin
        asleep_d = in_sleep;
        flush_d = 1'b0;
        block_d = block_q;
        if (in_sleep != asleep_q) begin
            if (fifo_gate) begin
                block_d = 1'b1; // [R19]
            end else begin
                flush_d = 1'b1; // [R19]
            end
        end else if (fifo_empty || !fifo_gate) begin
            // host emptied it or the gate is clear; a new transition still wins above
            block_d = 1'b0; // [R19]
        end
    end

    // fifo gating state
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            asleep_q <= 1'b0;
            flush_q <= 1'b0;
            block_q <= 1'b0;
        end else begin
            asleep_q <= asleep_d;
            flush_q <= flush_d;
            block_q <= block_d;
        end
    end

    assign fifo_flush = flush_q;
    assign fifo_input_block = block_q;

    // low noise limits the range; higher thresholds are never reached
    always_comb begin
        sample_out = sample_in;
        if (low_noise_select) begin
            if (sample_in > `ACSC_LOW_NOISE_LIMIT) begin
                sample_out = `ACSC_LOW_NOISE_LIMIT; // [R7]
            end else if (sample_in < -`ACSC_LOW_NOISE_LIMIT) begin
                sample_out = -`ACSC_LOW_NOISE_LIMIT; // [R7]
            end
        end
    end

endmodule : acsc_sys_ctrl

// ===== verif/acsc_host_model.sv
`timescale 1ns/1ps
// host behind the serial engine: one register access per wr or rd call
module acsc_host_model (
    input wire logic clk_sys,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd
);
    // idle bus from time zero
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
        reg_rd = 1'b0;
    end
    // strobe stands for exactly one taken edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d; // stale data must not look valid
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask : rd
    // control one: standby first, fields next, then go active when d[0] is set
    task automatic cfg1(input logic [7:0] d);
        wr(8'h2a, 8'h00);
        wr(8'h2a, d & 8'hfe);
        if (d[0]) begin
            wr(8'h2a, d);
        end
    endtask : cfg1
endmodule : acsc_host_model

// ===== verif/acsc_sys_ctrl_monitor.sv
`timescale 1ns/1ps
// port-level watcher of the control bank
module acsc_sys_ctrl_monitor (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] ptr_cur,
    input wire logic [7:0] ptr_next,
    input wire logic asleep,
    input wire logic fifo_msb_only,
    input wire logic wake_request,
    input wire logic signed [13:0] sample_in,
    input wire logic signed [13:0] sample_out,
    input wire logic active_mode,
    input wire logic sleep_allowed,
    input wire logic low_noise_select,
    input wire logic [2:0] run_rate_code,
    input wire logic [19:0] run_period_us,
    input wire logic [10:0] run_os_ratio,
    input wire logic serial_reset
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // soft reset wipes the bank and starts the boot window
    a_soft_clear: assert property (
        reg_wr && !serial_reset && reg_addr == 8'h2b && reg_wdata[6]
        |=> serial_reset && !active_mode && !low_noise_select)
        else $error("soft reset left state behind");
    // boot window is exactly 100 cycles
    a_boot_len: assert property (
        $rose(serial_reset) |-> ##99 serial_reset ##1 !serial_reset)
        else $error("boot window length wrong");
    // active writes to control one touch only the active bit
    a_active_lock: assert property (
        reg_wr && !serial_reset && active_mode && reg_addr == 8'h2a
        |=> $stable(low_noise_select) && $stable(fifo_msb_only))
        else $error("field changed while active");
    a_fast_step: assert property (
        fifo_msb_only && ptr_cur == 8'h01 |-> ptr_next == 8'h03)
        else $error("fast read did not skip low byte");
    a_noise_clamp: assert property (
        low_noise_select && sample_in > 14'sh0fff |-> sample_out == 14'sh0fff)
        else $error("low noise clamp missing");
    a_sleep_rate: assert property (
        asleep && sleep_allowed |-> run_rate_code[2])
        else $error("sleep rate not in force");
    a_wake_gate: assert property (
        wake_request |-> asleep && sleep_allowed && active_mode)
        else $error("wake request outside sleep");
    a_fast_ratio: assert property (
        run_rate_code == 3'h0 |-> run_os_ratio == 11'h002
        && run_period_us == 20'h004e2)
        else $error("800 Hz ratio or period wrong");
    a_slow_period: assert property (
        run_rate_code == 3'h7 |-> run_period_us == 20'h9c400)
        else $error("slowest period wrong");
    c_boot: cover property ($rose(serial_reset));
    c_wake: cover property (wake_request);
    c_clamp: cover property (low_noise_select && sample_in > 14'sh0fff);
endmodule : acsc_sys_ctrl_monitor

bind acsc_sys_ctrl acsc_sys_ctrl_monitor u_mon (
    .clk_sys, .resetn, .reg_addr, .reg_wr, .reg_wdata, .ptr_cur,
    .ptr_next, .asleep, .fifo_msb_only, .wake_request, .sample_in,
    .sample_out, .active_mode, .sleep_allowed, .low_noise_select,
    .run_rate_code, .run_period_us, .run_os_ratio, .serial_reset
);

// ===== verif/tb.sv
`timescale 1ns/1ps
// drives the bank through the host model and checks outputs
module tb;
    import acsc_pkg::*;
    logic clk_sys = 1'b0;
    logic resetn;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ptr_cur, ptr_next, d;
    logic reg_wr, reg_rd, reg_hit, asleep, fifo_empty, fifo_flush;
    logic [1:0] fifo_operating_mode;
    logic [3:0] ev; // transient, orientation, pulse, fall/motion
    logic signed [13:0] sample_in, sample_out, smp;
    logic fifo_input_block, fifo_msb_only, wake_request, active_mode;
    logic sleep_allowed, self_test_enable, low_noise_select;
    logic irq_polarity, irq_drive_type, serial_reset;
    logic [2:0] run_rate_code;
    acsc_os_scheme_t run_scheme;
    logic [19:0] run_period_us;
    logic [10:0] run_os_ratio;
    int failures = 0;
    int compares = 0;
    int flushes = 0;
    int n;
    logic rd_pend = 1'b0;
    logic [7:0] exp_q[$];
    // averaging ratio per scheme, rate codes 0 to 7
    int ratio[4][8] = '{'{2, 4, 4, 4, 4, 16, 32, 128},
        '{2, 4, 4, 4, 4, 4, 8, 32}, '{2, 4, 8, 16, 32, 128, 256, 1024},
        '{2, 2, 2, 2, 2, 2, 4, 16}};
    int period[8] = '{1250, 2500, 5000, 10000, 20000, 80000, 160000, 640000};
    acsc_sys_ctrl u_dut (
        .clk_sys, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
        .reg_rdata, .reg_hit, .ptr_cur, .ptr_next, .asleep,
        .fifo_operating_mode, .fifo_empty, .fifo_flush, .fifo_input_block,
        .fifo_msb_only, .transient_event(ev[3]), .orientation_event(ev[2]),
        .pulse_event(ev[1]), .fall_motion_event(ev[0]), .wake_request,
        .sample_in, .sample_out, .active_mode, .sleep_allowed,
        .self_test_enable, .low_noise_select, .irq_polarity,
        .irq_drive_type, .run_rate_code, .run_scheme, .run_period_us,
        .run_os_ratio, .serial_reset
    );
    acsc_host_model u_host (.clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
    always #5 clk_sys = ~clk_sys;
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick
    // note the answer first, then issue the read
    task automatic rd_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        u_host.rd(a);
    endtask : rd_exp
    task automatic end_sim;
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim
    // read data lands on the edge after the taken read
    always @(posedge clk_sys) begin
        if (rd_pend) begin
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
        rd_pend <= reg_rd;
        if (fifo_flush === 1'b1) begin
            flushes++;
        end
    end
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        end_sim();
    end
    initial begin
        resetn = 1'b0;
        asleep = 1'b0;
        fifo_empty = 1'b1;
        fifo_operating_mode = 2'h0;
        ev = 4'h0;
        sample_in = 14'h0000;
        ptr_cur = 8'h00;
        void'($urandom(32'h1b32a6aa));
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        rd_exp(8'h2a, 8'h00);
        rd_exp(8'h2b, 8'h00);
        rd_exp(8'h2c, 8'h00);
        u_host.wr(8'h2d, 8'hff);
        rd_exp(8'h2d, 8'h00);
        chk("hit", 0, reg_hit);
        // random field patterns in standby, reserved bits must read zero
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom()) & 8'hfe;
            u_host.cfg1(d);
            rd_exp(8'h2a, d);
            d = 8'($urandom()) & 8'hbf;
            u_host.wr(8'h2b, d);
            rd_exp(8'h2b, d & 8'h9f);
            chk("self_test", d[7], self_test_enable);
            d = 8'($urandom());
            u_host.wr(8'h2c, d);
            rd_exp(8'h2c, d & 8'hfb);
            chk("irq_pol", d[1], irq_polarity);
            chk("irq_drv", d[0], irq_drive_type);
            chk("hit", 1, reg_hit);
        end
        // every rate code against every scheme
        for (int s = 0; s < 4; s++) begin
            for (int r = 0; r < 8; r++) begin
                u_host.wr(8'h2a, {2'h0, 3'(r), 3'h0});
                u_host.wr(8'h2b, {6'h00, 2'(s)});
                tick(1);
                chk("rate", r, run_rate_code);
                chk("scheme", s, run_scheme);
                chk("ratio", ratio[s][r], run_os_ratio);
                chk("period", period[r], run_period_us);
            end
        end
        // auto-sleep with the gate clear: one flush per transition
        u_host.wr(8'h2c, 8'h00);
        u_host.cfg1(8'h89);
        u_host.wr(8'h2b, 8'h1c);
        tick(1);
        chk("active", 1, active_mode);
        chk("slp_ok", 1, sleep_allowed);
        chk("run_rate", 3'h1, run_rate_code);
        n = flushes;
        @(posedge clk_sys);
        asleep <= 1'b1;
        tick(4);
        chk("flushes", n + 1, flushes);
        chk("run_rate", 3'h6, run_rate_code);
        chk("scheme", 3, run_scheme);
        // each source wakes only when its own enable is set
        for (int i = 0; i < 4; i++) begin
            u_host.wr(8'h2c, 8'h08 << i);
            ev <= 4'h1 << i;
            tick(1);
            chk("wake", 1, wake_request);
            u_host.wr(8'h2c, 8'h08 << ((i + 1) % 4));
            tick(1);
            chk("wake", 0, wake_request);
            @(posedge clk_sys);
            ev <= 4'h0;
        end
        // gate set: input held until the host empties the fifo
        u_host.wr(8'h2c, 8'h80);
        fifo_empty <= 1'b0;
        asleep <= 1'b0;
        tick(3);
        chk("fifo_blk", 1, fifo_input_block);
        @(posedge clk_sys);
        fifo_empty <= 1'b1;
        tick(3);
        chk("fifo_blk", 0, fifo_input_block);
        // while active only the active bit follows a write
        u_host.wr(8'h2a, 8'hfd);
        rd_exp(8'h2a, 8'h89);
        u_host.wr(8'h2a, 8'hfc);
        rd_exp(8'h2a, 8'h88);
        chk("slp_ok", 0, sleep_allowed);
        // low noise clamp and fast read, fifo off
        u_host.wr(8'h2a, 8'h06);
        smp = 14'($urandom_range(8191, 4096));
        sample_in <= smp;
        ptr_cur <= 8'h01;
        tick(1);
        chk("clamp", 14'h0fff, $unsigned(sample_out));
        chk("ptr", 8'h03, ptr_next);
        chk("msb_only", 1, fifo_msb_only);
        chk("low_noise_select", 1, low_noise_select);
        @(posedge clk_sys);
        sample_in <= -smp;
        fifo_operating_mode <= 2'h1;
        tick(1);
        chk("clamp", 14'h3001, $unsigned(sample_out));
        // fast read must hold while the fifo runs
        u_host.wr(8'h2a, 8'h04);
        rd_exp(8'h2a, 8'h06);
        @(posedge clk_sys);
        fifo_operating_mode <= 2'h0;
        // soft reset while active, write during boot is dropped
        u_host.cfg1(8'h01);
        u_host.wr(8'h2b, 8'h44);
        tick(1);
        chk("ser_rst", 1, serial_reset);
        chk("active", 0, active_mode);
        u_host.wr(8'h2a, 8'h08);
        n = 0;
        while (serial_reset !== 1'b0 && n < 150) begin
            tick(1);
            n++;
        end
        chk("ser_rst", 0, serial_reset);
        rd_exp(8'h2a, 8'h00);
        rd_exp(8'h2b, 8'h00);
        rd_exp(8'h2c, 8'h00);
        tick(3);
        end_sim();
    end
endmodule : tb
